// *** hdl/wake_pkg.sv ***
// Purpose: Shared constants for the wake input monitor
// Assumes: 50 MHz clock, 32-bit AXI4-Lite register bus
// Notes: Offsets are byte addresses
package wake_pkg;
	localparam int CLK_MHZ = 50;
	localparam int FILT_SHORT_US = 16;
	localparam int FILT_LONG_US = 64;
	localparam int FILT_SHORT_CYC = FILT_SHORT_US * CLK_MHZ;
	localparam int FILT_LONG_CYC = FILT_LONG_US * CLK_MHZ;
	localparam logic [7:0] OFS_WAKE_EN = 8'h00;
	localparam logic [7:0] OFS_PULL = 8'h04;
	localparam logic [7:0] OFS_FILTER = 8'h08;
	localparam logic [7:0] OFS_SRC = 8'h0c;
	localparam logic [7:0] OFS_ALT_SRC = 8'h10;
	localparam logic [7:0] OFS_LEVEL = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_MODE = 8'h1c;
	localparam logic [7:0] OFS_ALT_CFG = 8'h20;
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [1:0] PULL_AUTO = 2'h3;
	localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
	localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
	localparam logic [1:0] FLT_CYCLIC_T1 = 2'h2;
	localparam logic [1:0] FLT_CYCLIC_T2 = 2'h3;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_STOP = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;
	localparam logic [1:0] MODE_FAILSAFE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wake_pkg

// *** hdl/sync_2ff.sv ***
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Single clock, synchronous active-low reset
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module sync_2ff
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Data
	input wire logic d,
	output logic q
);
	logic meta;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta <= 1'b0;
			q <= 1'b0;
		end
		else if (ce)
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : sync_2ff

// *** hdl/edge_filter.sv ***
// Purpose: Glitch filter reporting both edges of one input
// Assumes: Input already synchronised
// Notes: Any crossing back during the interval restarts it
`timescale 1ns/1ps
module edge_filter #(
	parameter int CNT_W = 12
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Control
	input wire logic active,
	input wire logic [CNT_W-1:0] filt_cycles,
	// Data
	input wire logic din,
	output logic level,
	output logic edge_pulse
);
	logic [CNT_W-1:0] cnt;

	// Level accepted only after stable for the whole interval
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= '0;
			level <= 1'b0;
			edge_pulse <= 1'b0;
		end
		else if (ce)
		begin
			edge_pulse <= 1'b0;
			if (!active || din == level)
				cnt <= '0;
			else if (cnt + 1'b1 >= filt_cycles)
			begin
				cnt <= '0;
				level <= din;
				edge_pulse <= 1'b1;
			end
			else
				cnt <= cnt + 1'b1;
		end
	end
endmodule : edge_filter

// *** hdl/wake_input_monitor.sv ***
// Purpose: Wake input monitor with AXI4-Lite registers
// Assumes: 50 MHz aclk, pins synchronous-capable after two flops
// Notes: Events latch sticky flags, write one to clear
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wake_input_monitor #(
	parameter int N_WAKE = 3,
	parameter int N_ALT = 2,
	parameter int CNT_W = 12
)
(
	// Clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and mode
	input wire logic [N_WAKE-1:0] wake_input_pin,
	input wire logic [N_ALT-1:0] failsafe_output_pins,
	input wire logic cyclic_timer_one_window,
	input wire logic cyclic_timer_two_window,
	// Outputs
	output logic [N_WAKE-1:0] pull_up_en,
	output logic [N_WAKE-1:0] pull_down_en,
	output logic irq,
	output logic wake_request
);
	localparam logic [CNT_W-1:0] SHORT_CYC =
		CNT_W'(wake_pkg::FILT_SHORT_CYC);
	localparam logic [CNT_W-1:0] LONG_CYC =
		CNT_W'(wake_pkg::FILT_LONG_CYC);

	// Registers
	logic [N_WAKE-1:0] wake_enable_control;
	logic [2*N_WAKE-1:0] wake_pull_control;
	logic [2*N_WAKE-1:0] wake_filter_control;
	logic [N_WAKE-1:0] wake_source_status;
	logic [N_ALT-1:0] alt_wake_source_status;
	logic [N_WAKE-1:0] wake_pin_level_status;
	logic [N_WAKE+N_ALT-1:0] irq_mask;
	logic [1:0] power_mode;
	logic [N_ALT-1:0] alt_wake_cfg;

	// Filtered signals
	logic [N_WAKE-1:0] wk_sync;
	logic [N_WAKE-1:0] wk_level;
	logic [N_WAKE-1:0] wk_edge;
	logic [N_WAKE-1:0] wk_active;
	logic [N_WAKE-1:0] wk_cyclic;
	logic [N_ALT-1:0] alt_sync;
	logic [N_ALT-1:0] alt_edge;
	logic [N_WAKE-1:0] next_src;
	logic [N_ALT-1:0] next_alt;
	logic low_power;

	// Bus state
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;

	assign low_power = power_mode == wake_pkg::MODE_SLEEP ||
		power_mode == wake_pkg::MODE_FAILSAFE;

	genvar gi;
	generate
		for (gi = 0; gi < N_WAKE; gi++)
		begin : g_wake
			logic [1:0] fsel;
			logic [1:0] psel;
			logic [CNT_W-1:0] fcyc;
			logic cyc_t1;
			logic cyc_t2;
			logic auto_pull;
			assign fsel = wake_filter_control[2*gi +: 2];
			assign psel = wake_pull_control[2*gi +: 2];
			assign auto_pull = psel == wake_pkg::PULL_AUTO;
			// Filter code selects static or timer-gated sense
			assign cyc_t1 = fsel == wake_pkg::FLT_CYCLIC_T1;
			assign cyc_t2 = fsel == wake_pkg::FLT_CYCLIC_T2;
			assign wk_cyclic[gi] = cyc_t1 || cyc_t2;
			assign wk_active[gi] = cyc_t1 ? cyclic_timer_one_window :
				cyc_t2 ? cyclic_timer_two_window : 1'b1;
			assign fcyc = fsel == wake_pkg::FLT_STATIC_LONG ? LONG_CYC :
				SHORT_CYC;
			sync_2ff u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.d(wake_input_pin[gi]),
				.q(wk_sync[gi])
			);
			edge_filter #(.CNT_W(CNT_W)) u_filt (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.active(wk_active[gi]),
				.filt_cycles(fcyc),
				.din(wk_sync[gi]),
				.level(wk_level[gi]),
				.edge_pulse(wk_edge[gi])
			);
			// Pull sources from code and detected level
			assign pull_up_en[gi] = psel == wake_pkg::PULL_UP ||
				(auto_pull && wk_level[gi]);
			assign pull_down_en[gi] = psel == wake_pkg::PULL_DOWN ||
				(auto_pull && !wk_level[gi]);
		end
		for (gi = 0; gi < N_ALT; gi++)
		begin : g_alt
			sync_2ff u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.d(failsafe_output_pins[gi]),
				.q(alt_sync[gi])
			);
			edge_filter #(.CNT_W(CNT_W)) u_filt (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.active(alt_wake_cfg[gi]),
				.filt_cycles(SHORT_CYC),
				.din(alt_sync[gi]),
				.level(),
				.edge_pulse(alt_edge[gi])
			);
		end
	endgenerate

	// Level status outside sleep/failsafe: live when static, sampled inside window
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wake_pin_level_status <= '0;
		else if (ce && !low_power)
		begin
			for (int i = 0; i < N_WAKE; i++)
				if (!wk_cyclic[i] || wk_active[i])
					wake_pin_level_status[i] <= wk_sync[i];
		end
	end

	// Sticky flags; a new event beats a clear in the same cycle
	always_comb
	begin
		next_src = wake_source_status;
		next_alt = alt_wake_source_status;
		if (wr_go && aw_addr == wake_pkg::OFS_SRC && w_strb[0])
			next_src = next_src & ~w_data[N_WAKE-1:0];
		if (wr_go && aw_addr == wake_pkg::OFS_ALT_SRC && w_strb[0])
			next_alt = next_alt & ~w_data[N_ALT-1:0];
		next_src = next_src | (wk_edge & wake_enable_control);
		next_alt = next_alt | alt_edge;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wake_source_status <= '0;
			alt_wake_source_status <= '0;
		end
		else if (ce)
		begin
			wake_source_status <= next_src;
			alt_wake_source_status <= next_alt;
		end
	end

	// Interrupt in normal/stop, wake request in sleep/failsafe
	always_comb
	begin
		irq = !low_power && |({alt_wake_source_status,
			wake_source_status} & irq_mask);
		wake_request = low_power &&
			|{alt_wake_source_status, wake_source_status};
	end

	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= wake_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? wake_pkg::RESP_OKAY :
					wake_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		unique case (aw_addr)
			wake_pkg::OFS_WAKE_EN, wake_pkg::OFS_PULL,
			wake_pkg::OFS_FILTER, wake_pkg::OFS_SRC,
			wake_pkg::OFS_ALT_SRC, wake_pkg::OFS_IRQ_MASK,
			wake_pkg::OFS_MODE, wake_pkg::OFS_ALT_CFG,
			wake_pkg::OFS_LEVEL: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Control registers, low byte lane only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wake_enable_control <= '0;
			wake_pull_control <= '0;
			wake_filter_control <= '0;
			irq_mask <= '0;
			power_mode <= wake_pkg::MODE_NORMAL;
			alt_wake_cfg <= '0;
		end
		else if (ce && wr_go && w_strb[0])
		begin
			unique case (aw_addr)
				wake_pkg::OFS_WAKE_EN:
					wake_enable_control <= w_data[N_WAKE-1:0];
				wake_pkg::OFS_PULL:
					wake_pull_control <= w_data[2*N_WAKE-1:0];
				wake_pkg::OFS_FILTER:
					wake_filter_control <= w_data[2*N_WAKE-1:0];
				wake_pkg::OFS_IRQ_MASK:
					irq_mask <= w_data[N_WAKE+N_ALT-1:0];
				wake_pkg::OFS_MODE: power_mode <= w_data[1:0];
				wake_pkg::OFS_ALT_CFG: alt_wake_cfg <= w_data[N_ALT-1:0];
				default: ;
			endcase
		end
	end

	// Read channel
	always_comb
	begin
		rd_val = 32'h0;
		rd_ok = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			wake_pkg::OFS_WAKE_EN: rd_val[N_WAKE-1:0] = wake_enable_control;
			wake_pkg::OFS_PULL: rd_val[2*N_WAKE-1:0] = wake_pull_control;
			wake_pkg::OFS_FILTER: rd_val[2*N_WAKE-1:0] = wake_filter_control;
			wake_pkg::OFS_SRC: rd_val[N_WAKE-1:0] = wake_source_status;
			wake_pkg::OFS_ALT_SRC: rd_val[N_ALT-1:0] = alt_wake_source_status;
			wake_pkg::OFS_LEVEL:
				rd_val[N_WAKE-1:0] = wake_pin_level_status;
			wake_pkg::OFS_IRQ_MASK: rd_val[N_WAKE+N_ALT-1:0] = irq_mask;
			wake_pkg::OFS_MODE: rd_val[1:0] = power_mode;
			wake_pkg::OFS_ALT_CFG: rd_val[N_ALT-1:0] = alt_wake_cfg;
			default: rd_ok = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= wake_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && !s_axi_rvalid)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? wake_pkg::RESP_OKAY :
					wake_pkg::RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule : wake_input_monitor

// *** test/wake_checker.sv ***
// Purpose: Port assertions for the wake monitor
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every monitor instance
`timescale 1ns/1ps
module wake_checker #(
	parameter int N_WAKE = 3
)
(
	// Clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Outputs
	input wire logic [N_WAKE-1:0] pull_up_en,
	input wire logic [N_WAKE-1:0] pull_down_en,
	input wire logic irq,
	input wire logic wake_request
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		ce && s_axi_arvalid && s_axi_arready;
	endsequence
	property p_b_after_wr;
		s_wr_taken |-> ##2 s_axi_bvalid;
	endproperty
	property p_r_after_rd;
		s_rd_taken |=> s_axi_rvalid;
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_pull_excl;
		(pull_up_en & pull_down_en) == '0;
	endproperty
	property p_irq_wake;
		!(irq && wake_request);
	endproperty
	property p_reset_idle;
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
			&& pull_up_en == '0 && pull_down_en == '0;
	endproperty
	property p_irq_sticky;
		$fell(irq) |-> $rose(s_axi_bvalid);
	endproperty
	property p_wake_sticky;
		$fell(wake_request) |-> $rose(s_axi_bvalid);
	endproperty
	a_b_after_wr: assert property (p_b_after_wr)
		else $error("write response late");
	a_r_after_rd: assert property (p_r_after_rd)
		else $error("read data late");
	a_ar_block: assert property (p_ar_block)
		else $error("read address open while data pending");
	a_pull_excl: assert property (p_pull_excl)
		else $error("pull up and down both on");
	a_irq_wake: assert property (p_irq_wake)
		else $error("interrupt and wake together");
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");
	a_irq_sticky: assert property (p_irq_sticky)
		else $error("interrupt dropped without a write");
	a_wake_sticky: assert property (p_wake_sticky)
		else $error("wake dropped without a write");
endmodule : wake_checker
bind wake_input_monitor wake_checker #(.N_WAKE(N_WAKE)) u_chk (.*);

// *** test/wake_pin_env.sv ***
// Purpose: External circuit on the wake pins
// Assumes: Bench drives or releases each pin
// Notes: Released pin with no pull shows the inverse level
`timescale 1ns/1ps
module wake_pin_env
(
	// Bench side
	input wire logic [2:0] drv_en,
	input wire logic [2:0] drv_val,
	// Pull sources
	input wire logic [2:0] pull_up_en,
	input wire logic [2:0] pull_down_en,
	// Pins
	output logic [2:0] pin
);
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (drv_en[i])
				pin[i] = drv_val[i];
			else if (pull_up_en[i])
				pin[i] = 1'b1;
			else if (pull_down_en[i])
				pin[i] = 1'b0;
			else
				pin[i] = ~drv_val[i];
		end
	end
endmodule : wake_pin_env

// *** test/tb_wake_input_monitor.sv ***
// Purpose: Register-level test of the wake monitor
// Assumes: Bus ready inputs held high
// Notes: Filter waits use 900 and 3400 cycles
`timescale 1ns/1ps
module tb_wake_input_monitor;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, win1 = 1'b0;
	logic win2 = 1'b0, ce = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, d, rdata;
	logic [2:0] den = 3'h7, dval = 3'h0, pin, pu, pd;
	logic [1:0] fo = 2'h0, r, bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, irq, wreq;
	int n_mismatch = 0, n_compared = 0, cycles = 0;
	always #10 aclk = ~aclk;
	wake_input_monitor u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .wake_input_pin(pin),
		.failsafe_output_pins(fo), .cyclic_timer_one_window(win1),
		.cyclic_timer_two_window(win2), .pull_up_en(pu),
		.pull_down_en(pd), .irq(irq), .wake_request(wreq));
	wake_pin_env u_env (.drv_en(den), .drv_val(dval), .pull_up_en(pu),
		.pull_down_en(pd), .pin(pin));
	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
	endtask : wr
	task rd(input logic [7:0] a);
		logic ta, tb;
		araddr <= a;
		arvalid <= 1'b1;
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tb = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, d, e);
	endtask : rc
	initial
	begin
		cyc(2);
		aresetn <= 1'b1;
		for (int a = 0; a <= 32; a += 4)
			rc(8'(a), 32'h0, "reset_value");
		rd(8'h40);
		chk("read_unmapped", r, wake_pkg::RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk("write_unmapped", r, wake_pkg::RESP_SLVERR);
		$display("test registers done");
		wr(8'h04, 32'h39);
		chk("pull_up", pu, 3'h2);
		chk("pull_down", pd, 3'h5);
		wr(8'h00, 32'h7);
		wr(8'h18, 32'h1f);
		dval <= 3'h1;
		cyc(400);
		dval <= 3'h0;
		cyc(900);
		rc(8'h0c, 32'h0, "glitch");
		dval <= 3'h1;
		cyc(900);
		rc(8'h0c, 32'h1, "rise");
		chk("irq", irq, 1'b1);
		rc(8'h14, 32'h1, "level");
		wr(8'h0c, 32'h1);
		chk("irq_clear", irq, 1'b0);
		dval <= 3'h0;
		cyc(900);
		rc(8'h0c, 32'h1, "fall");
		wr(8'h0c, 32'h1);
		$display("test static done");
		wr(8'h08, 32'h4);
		dval <= 3'h2;
		cyc(2000);
		rc(8'h0c, 32'h0, "long_early");
		cyc(1400);
		rc(8'h0c, 32'h2, "long");
		dval <= 3'h6;
		cyc(900);
		chk("auto_up", pu, 3'h6);
		wr(8'h0c, 32'h6);
		den <= 3'h3;
		cyc(900);
		rc(8'h0c, 32'h0, "auto_hold");
		$display("test pulls done");
		wr(8'h1c, 32'h2);
		dval <= 3'h7;
		cyc(900);
		chk("wake", wreq, 1'b1);
		chk("no_irq", irq, 1'b0);
		wr(8'h0c, 32'h1);
		wr(8'h1c, 32'h0);
		$display("test sleep done");
		wr(8'h08, 32'h2);
		dval <= 3'h6;
		cyc(900);
		rc(8'h0c, 32'h0, "cyclic_off");
		rc(8'h14, 32'h7, "cyclic_hold");
		win1 <= 1'b1;
		cyc(900);
		wr(8'h0c, 32'h1);
		dval <= 3'h7;
		cyc(900);
		rc(8'h0c, 32'h1, "cyclic_on");
		rc(8'h14, 32'h7, "cyclic_level");
		$display("test cyclic done");
		wr(8'h0c, 32'h1);
		wr(8'h20, 32'h1);
		fo <= 2'h1;
		cyc(900);
		rc(8'h10, 32'h1, "alt");
		chk("alt_irq", irq, 1'b1);
		wr(8'h10, 32'h1);
		rc(8'h10, 32'h0, "alt_clear");
		$display("test alternate done");
		wr(8'h1c, 32'h1);
		wr(8'h08, 32'h30);
		den <= 3'h7;
		dval <= 3'h3;
		cyc(900);
		rc(8'h0c, 32'h0, "t2_off");
		rc(8'h14, 32'h7, "t2_hold");
		win2 <= 1'b1;
		cyc(900);
		rc(8'h0c, 32'h4, "t2_on");
		rc(8'h14, 32'h3, "stop_level");
		chk("stop_irq", irq, 1'b1);
		chk("stop_no_wake", wreq, 1'b0);
		wr(8'h0c, 32'h4);
		ce <= 1'b0;
		dval <= 3'h7;
		cyc(900);
		ce <= 1'b1;
		rc(8'h0c, 32'h0, "ce_freeze");
		cyc(900);
		rc(8'h0c, 32'h4, "ce_run");
		wr(8'h1c, 32'h3);
		chk("failsafe_wake", wreq, 1'b1);
		chk("failsafe_no_irq", irq, 1'b0);
		$display("test timer two done");
		finish_test();
	end
endmodule : tb_wake_input_monitor
